//--- design/bscrc_buf.sv
// two-entry byte buffer with valid/ready on both sides
// assumes clk/rst/ce shared with the generator
`timescale 1ns/1ps
module bscrc_buf (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic inValid,
    output logic inReady,
    input wire logic [bscrc_pkg::DATA_W-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [bscrc_pkg::DATA_W-1:0] outData
);

    bscrc_pkg::bscrc_buf_state_t st_ff;
    bscrc_pkg::bscrc_buf_state_t nxt_st;
    logic push;
    logic pop;

    // ****************************************
    // handshakes
    // ****************************************
    assign inReady = (st_ff.cnt != bscrc_pkg::BUF_CNT_FULL);
    assign outValid = (st_ff.cnt != bscrc_pkg::BUF_CNT_ZERO);
    assign outData = st_ff.mem[st_ff.rp];
    assign push = ce && inValid && inReady;
    assign pop = ce && outValid && outReady;

    // next state: store, advance pointers, count
    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wp] = inData;
            nxt_st.wp = st_ff.wp + 1'b1;
        end
        if (pop) begin
            nxt_st.rp = st_ff.rp + 1'b1;
        end
        if (push && !pop) begin
            nxt_st.cnt = st_ff.cnt + bscrc_pkg::BUF_CNT_ONE;
        end else if (pop && !push) begin
            nxt_st.cnt = st_ff.cnt - bscrc_pkg::BUF_CNT_ONE;
        end
    end

    // state register, frozen while ce is low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_buf_count_bound: assert property (@(posedge clk) disable iff (rst)
        st_ff.cnt <= bscrc_pkg::BUF_CNT_FULL)
        else $error("buffer count above depth");
    a_buf_full_held: assert property (@(posedge clk) disable iff (rst)
        (!inReady && ce && !outReady) |=> !inReady && $stable(outData))
        else $error("full buffer lost or changed a word");

endmodule : bscrc_buf

//--- design/bscrc_pkg.sv
// byte-serial crc16 generator: shared constants and types
// assumes one clock domain and an 8-bit register port
package bscrc_pkg;

    // ****************************************
    // register port layout
    // ****************************************
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int SUM_W = 16;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_INPUT = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_SUM_LOW = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_SUM_HIGH = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h4;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int POLYNOMIAL_SELECT_BIT = 0;
    localparam int STAT_ROOM_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [SUM_W-1:0] SUM_RESET = 16'h0000;

    // ****************************************
    // polynomials
    // ****************************************
    localparam logic POLYNOMIAL_SELECT_SEL_CCITT = 1'b0;
    localparam logic POLYNOMIAL_SELECT_SEL_CRC16 = 1'b1;
    localparam logic [SUM_W-1:0] POLYNOMIAL_SELECT_CCITT = 16'h1021;
    localparam logic [SUM_W-1:0] POLYNOMIAL_SELECT_CRC16 = 16'h8005;

    // ****************************************
    // input buffer
    // ****************************************
    localparam int BUF_DEPTH = 2;
    localparam int BUF_PTR_W = 1;
    localparam int BUF_CNT_W = 2;
    localparam logic [BUF_CNT_W-1:0] BUF_CNT_ZERO = 2'h0;
    localparam logic [BUF_CNT_W-1:0] BUF_CNT_ONE = 2'h1;
    localparam logic [BUF_CNT_W-1:0] BUF_CNT_FULL = 2'h2;

    // register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } bscrc_req_t;

    // whole state of the generator
    typedef struct packed {
        logic polySel;
        logic [DATA_W-1:0] inByte;
        logic [SUM_W-1:0] sum;
        logic [DATA_W-1:0] rdData;
    } bscrc_state_t;

    // whole state of the buffer
    typedef struct packed {
        logic [BUF_DEPTH-1:0][DATA_W-1:0] mem;
        logic [BUF_PTR_W-1:0] wp;
        logic [BUF_PTR_W-1:0] rp;
        logic [BUF_CNT_W-1:0] cnt;
    } bscrc_buf_state_t;

    localparam bscrc_state_t STATE_RESET = '{
        polySel: POLYNOMIAL_SELECT_SEL_CCITT, inByte: BYTE_ZERO,
        sum: SUM_RESET, rdData: BYTE_ZERO};

endpackage : bscrc_pkg

//--- design/bscrc_top.sv
// byte-serial crc16 generator with 8-bit register port
// assumes a single-cycle strobe master on clk, no wait states
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
module bscrc_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [bscrc_pkg::ADDR_W-1:0] regAddr,
    input wire logic [bscrc_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [bscrc_pkg::DATA_W-1:0] regRdata,
    output logic inputReady,
    output logic busy,
    output logic [bscrc_pkg::SUM_W-1:0] runningChecksum
);

    // ****************************************
    // crc byte step
    // ****************************************

    // one byte folded into a checksum, eight bit steps unrolled by the loop
    function automatic logic [bscrc_pkg::SUM_W-1:0] crcByte(
        input logic polySel,
        input logic [bscrc_pkg::SUM_W-1:0] sumIn,
        input logic [bscrc_pkg::DATA_W-1:0] dataIn
    );
        logic [bscrc_pkg::SUM_W-1:0] tmp;
        logic [bscrc_pkg::SUM_W-1:0] polynomial_select;
        logic msb;
        polynomial_select = (polySel == bscrc_pkg::POLYNOMIAL_SELECT_SEL_CRC16) ?
            bscrc_pkg::POLYNOMIAL_SELECT_CRC16 : bscrc_pkg::POLYNOMIAL_SELECT_CCITT;
        tmp = sumIn ^ {dataIn, bscrc_pkg::BYTE_ZERO};
        for (int i = 0; i < bscrc_pkg::DATA_W; i++) begin
            msb = tmp[bscrc_pkg::SUM_W-1];
            tmp = {tmp[bscrc_pkg::SUM_W-2:0], 1'b0};
            if (msb) begin
                tmp = tmp ^ polynomial_select;
            end
        end
        return tmp;
    endfunction : crcByte

    // ****************************************
    // state and decode
    // ****************************************
    bscrc_pkg::bscrc_state_t st_ff;
    bscrc_pkg::bscrc_state_t nxt_st;
    bscrc_pkg::bscrc_req_t req;

    logic ctrlWr;
    logic inWr;
    logic lowWr;
    logic highWr;
    logic sumWr;
    logic bufValid;
    logic bufReady;
    logic [bscrc_pkg::DATA_W-1:0] bufData;
    logic engineTake;
    logic [bscrc_pkg::SUM_W-1:0] stepSum;
    logic [bscrc_pkg::DATA_W-1:0] rdMux;
    logic [bscrc_pkg::DATA_W-1:0] ctrlView;
    logic [bscrc_pkg::DATA_W-1:0] statView;

    // bundle the port into one request
    assign req.addr = regAddr;
    assign req.wdata = regWdata;
    assign req.wr = regWr;
    assign req.rd = regRd;

    // write strobes per register
    assign ctrlWr = req.wr && (req.addr == bscrc_pkg::ADDR_CTRL);
    assign inWr = req.wr && (req.addr == bscrc_pkg::ADDR_INPUT);
    assign lowWr = req.wr && (req.addr == bscrc_pkg::ADDR_SUM_LOW);
    assign highWr = req.wr && (req.addr == bscrc_pkg::ADDR_SUM_HIGH);
    assign sumWr = lowWr || highWr;

    // ****************************************
    // input byte buffer
    // ****************************************

    // each input write with room in the buffer is queued, a write while full is dropped; a stall of the engine back-pressures here
    bscrc_buf u_buf (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .inValid(inWr),
        .inReady(bufReady),
        .inData(req.wdata),
        .outValid(bufValid),
        .outReady(engineTake),
        .outData(bufData)
    );

    // engine yields to a direct checksum load in the same cycle
    assign engineTake = !sumWr;
    assign stepSum = crcByte(st_ff.polySel, st_ff.sum, bufData);

    // ****************************************
    // read views
    // ****************************************

    // control: only the select bit, the rest reads zero
    always_comb begin
        ctrlView = bscrc_pkg::BYTE_ZERO;
        ctrlView[bscrc_pkg::POLYNOMIAL_SELECT_BIT] = st_ff.polySel;
    end

    // status: room in the buffer and bytes pending
    always_comb begin
        statView = bscrc_pkg::BYTE_ZERO;
        statView[bscrc_pkg::STAT_ROOM_BIT] = bufReady;
        statView[bscrc_pkg::STAT_BUSY_BIT] = bufValid;
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        case (req.addr)
            bscrc_pkg::ADDR_CTRL: rdMux = ctrlView;
            bscrc_pkg::ADDR_INPUT: rdMux = st_ff.inByte;
            bscrc_pkg::ADDR_SUM_LOW: rdMux = st_ff.sum[bscrc_pkg::DATA_W-1:0];
            bscrc_pkg::ADDR_SUM_HIGH: rdMux = st_ff.sum[bscrc_pkg::SUM_W-1:bscrc_pkg::DATA_W];
            bscrc_pkg::ADDR_STATUS: rdMux = statView;
            default: rdMux = bscrc_pkg::BYTE_ZERO;
        endcase
    end

    // ****************************************
    // next state
    // ****************************************

    // register writes, checksum update and read capture
    always_comb begin
        nxt_st = st_ff;
        if (ctrlWr) begin
            nxt_st.polySel = req.wdata[bscrc_pkg::POLYNOMIAL_SELECT_BIT];
        end
        if (inWr && bufReady) begin
            nxt_st.inByte = req.wdata;
        end
        if (sumWr) begin
            if (lowWr) begin
                nxt_st.sum[bscrc_pkg::DATA_W-1:0] = req.wdata;
            end
            if (highWr) begin
                nxt_st.sum[bscrc_pkg::SUM_W-1:bscrc_pkg::DATA_W] = req.wdata;
            end
        end else if (bufValid) begin
            nxt_st.sum = stepSum;
        end
        nxt_st.rdData = req.rd ? rdMux : bscrc_pkg::BYTE_ZERO;
    end

    // state register, frozen while ce is low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= bscrc_pkg::STATE_RESET;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign regRdata = st_ff.rdData;
    assign inputReady = bufReady;
    assign busy = bufValid;
    assign runningChecksum = st_ff.sum;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // a lone byte 01 on a clear pair yields the polynomial itself
    sequence s_unit_byte;
        ce && bufValid && !sumWr && (st_ff.sum == bscrc_pkg::SUM_RESET)
            && (bufData == 8'h01);
    endsequence

    // an input write into an idle engine with the clock enabled
    sequence s_idle_write;
        ce && inWr && !bufValid && bufReady ##1 ce && !sumWr && !inWr;
    endsequence

    a_ccitt_unit: assert property (
        s_unit_byte and (st_ff.polySel == bscrc_pkg::POLYNOMIAL_SELECT_SEL_CCITT)
        |=> st_ff.sum == bscrc_pkg::POLYNOMIAL_SELECT_CCITT)
        else $error("ccitt step on byte 01 wrong");

    a_crc16_unit: assert property (
        s_unit_byte and (st_ff.polySel == bscrc_pkg::POLYNOMIAL_SELECT_SEL_CRC16)
        |=> st_ff.sum == bscrc_pkg::POLYNOMIAL_SELECT_CRC16)
        else $error("crc16 step on byte 01 wrong");

    a_update_latency: assert property (
        s_idle_write |=> !busy)
        else $error("byte not folded within two cycles");

    a_ctrl_read_zero: assert property (
        ce && req.rd && (req.addr == bscrc_pkg::ADDR_CTRL)
        |=> regRdata[bscrc_pkg::DATA_W-1:1] == 7'h00)
        else $error("control upper bits not zero");

    a_low_load: assert property (
        ce && lowWr |=> runningChecksum[bscrc_pkg::DATA_W-1:0] == $past(regWdata))
        else $error("low byte load not direct");

    a_high_load: assert property (
        ce && highWr
        |=> runningChecksum[bscrc_pkg::SUM_W-1:bscrc_pkg::DATA_W] == $past(regWdata))
        else $error("high byte load not direct");

    a_input_readback: assert property (
        ce && inWr && bufReady ##1 ce && req.rd && !req.wr
            && (req.addr == bscrc_pkg::ADDR_INPUT)
        |=> regRdata == $past(regWdata, 2))
        else $error("input read not last byte");

    a_read_no_effect: assert property (
        ce && req.rd && !bufValid |=> $stable(runningChecksum))
        else $error("read changed checksum");

    a_read_one_cycle: assert property (
        ce && !req.rd |=> regRdata == bscrc_pkg::BYTE_ZERO)
        else $error("read data outside its cycle");

    a_freeze_ce: assert property (
        !ce |=> $stable(runningChecksum) && $stable(regRdata))
        else $error("state moved with ce low");

    // ****************************************
    // register state and load paths
    // ****************************************

    // select bit moves only on a control write
    a_polynomial_select_write: assert property (
        ce && ctrlWr
        |=> st_ff.polySel == $past(regWdata[bscrc_pkg::POLYNOMIAL_SELECT_BIT]))
        else $error("select bit not written");

    a_polynomial_select_hold: assert property (
        ce && !ctrlWr
        |=> $stable(st_ff.polySel))
        else $error("select bit moved without a write");

    // input byte register follows accepted writes only
    a_input_capture: assert property (
        ce && inWr && bufReady
        |=> st_ff.inByte == $past(regWdata))
        else $error("input byte not captured");

    a_input_hold: assert property (
        ce && !(inWr && bufReady)
        |=> $stable(st_ff.inByte))
        else $error("input byte moved without a write");

    // checksum moves only on a pending byte or a load
    a_sum_quiet: assert property (
        ce && !bufValid && !sumWr
        |=> $stable(runningChecksum))
        else $error("checksum moved with nothing pending");

    a_low_keeps_high: assert property (
        ce && lowWr
        |=> runningChecksum[bscrc_pkg::SUM_W-1:bscrc_pkg::DATA_W] == $past(st_ff.sum[bscrc_pkg::SUM_W-1:bscrc_pkg::DATA_W]))
        else $error("low load touched high byte");

    a_high_keeps_low: assert property (
        ce && highWr
        |=> runningChecksum[bscrc_pkg::DATA_W-1:0] == $past(st_ff.sum[bscrc_pkg::DATA_W-1:0]))
        else $error("high load touched low byte");

    // an empty buffer always has room for a byte
    a_room_when_idle: assert property (
        !busy
        |-> inputReady)
        else $error("idle buffer refuses a byte");

    // ****************************************
    // read paths
    // ****************************************

    // read data is the register value of the strobe cycle
    a_read_high: assert property (
        ce && req.rd && (req.addr == bscrc_pkg::ADDR_SUM_HIGH)
        |=> regRdata == $past(st_ff.sum[bscrc_pkg::SUM_W-1:bscrc_pkg::DATA_W]))
        else $error("high byte read wrong");

    a_read_low: assert property (
        ce && req.rd && (req.addr == bscrc_pkg::ADDR_SUM_LOW)
        |=> regRdata == $past(st_ff.sum[bscrc_pkg::DATA_W-1:0]))
        else $error("low byte read wrong");

    a_read_input: assert property (
        ce && req.rd && (req.addr == bscrc_pkg::ADDR_INPUT)
        |=> regRdata == $past(st_ff.inByte))
        else $error("input byte read wrong");

    a_read_status: assert property (
        ce && req.rd && (req.addr == bscrc_pkg::ADDR_STATUS)
        |=> regRdata == {6'h00, $past(busy), $past(inputReady)})
        else $error("status read wrong");

    a_read_ctrl: assert property (
        ce && req.rd && (req.addr == bscrc_pkg::ADDR_CTRL)
        |=> regRdata[bscrc_pkg::POLYNOMIAL_SELECT_BIT] == $past(st_ff.polySel))
        else $error("select bit read wrong");

    a_unmapped_zero: assert property (
        ce && req.rd && (req.addr > bscrc_pkg::ADDR_STATUS)
        |=> regRdata == bscrc_pkg::BYTE_ZERO)
        else $error("unmapped read not zero");

    // ****************************************
    // single bytes on a cleared pair
    // ****************************************

    // one byte entering the engine on a cleared pair
    sequence s_from_zero(logic [bscrc_pkg::DATA_W-1:0] b);
        ce && bufValid && !sumWr && (st_ff.sum == bscrc_pkg::SUM_RESET)
            && (bufData == b);
    endsequence

    a_zero_byte: assert property (
        s_from_zero(8'h00)
        |=> st_ff.sum == bscrc_pkg::SUM_RESET)
        else $error("zero byte left a nonzero sum");

    a_ccitt_two: assert property (
        s_from_zero(8'h02) and (st_ff.polySel == bscrc_pkg::POLYNOMIAL_SELECT_SEL_CCITT)
        |=> st_ff.sum == 16'h2042)
        else $error("ccitt step on byte 02 wrong");

    a_crc16_two: assert property (
        s_from_zero(8'h02) and (st_ff.polySel == bscrc_pkg::POLYNOMIAL_SELECT_SEL_CRC16)
        |=> st_ff.sum == 16'h800F)
        else $error("crc16 step on byte 02 wrong");

    a_ccitt_seven: assert property (
        s_from_zero(8'h07) and (st_ff.polySel == bscrc_pkg::POLYNOMIAL_SELECT_SEL_CCITT)
        |=> st_ff.sum == 16'h70E7)
        else $error("ccitt step on byte 07 wrong");

    a_crc16_seven: assert property (
        s_from_zero(8'h07) and (st_ff.polySel == bscrc_pkg::POLYNOMIAL_SELECT_SEL_CRC16)
        |=> st_ff.sum == 16'h8011)
        else $error("crc16 step on byte 07 wrong");

endmodule : bscrc_top

//--- tb/bscrc_top_bench.sv
// self-checking bench for the byte-serial crc16 generator
// assumes bscrc_top with its 8-bit strobe register port
`timescale 1ns/1ps
module bscrc_top_bench;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic ce = 1'h1;
    logic [bscrc_pkg::ADDR_W-1:0] regAddr = 3'h0;
    logic [bscrc_pkg::DATA_W-1:0] regWdata = 8'h00;
    logic regWr = 1'h0;
    logic regRd = 1'h0;
    logic [bscrc_pkg::DATA_W-1:0] regRdata;
    logic inputReady;
    logic busy;
    logic [bscrc_pkg::SUM_W-1:0] runningChecksum;
    logic [31:0] lfsrState = 32'h46C3196A;
    logic [15:0] expSum = 16'h0000;
    logic [7:0] rdVal;
    logic polyNow = 1'h0;
    logic [7:0] lastIn = 8'h00;
    logic [7:0] seqBytes [4] = '{8'h78, 8'h56, 8'h34, 8'h12};
    int failures = 0;
    int checks_done = 0;

    bscrc_top dut_u (.clk(clk), .rst(rst), .ce(ce), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .inputReady(inputReady),
        .busy(busy), .runningChecksum(runningChecksum));

    // 40 mhz clock
    always #12.5 clk = ~clk;

    // ****************************************
    // expectation helpers
    // ****************************************
    function automatic logic [15:0] crc_step(input logic [15:0] sum, input logic [7:0] b, input logic p);
        logic [15:0] t;
        logic msb;
        t = sum ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) begin
            msb = t[15];
            t = {t[14:0], 1'h0};
            if (msb) t = t ^ (p ? 16'h8005 : 16'h1021);
        end
        return t;
    endfunction : crc_step

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr_next

    // ****************************************
    // compare, bus and closing tasks
    // ****************************************
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk16

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= 1'h1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'h0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        regRd <= 1'h1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'h0;
        #1 d = regRdata;
        @(posedge clk);
        #1 chk8("read data released", 8'h00, regRdata);
    endtask : rd

    task automatic feed(input logic [7:0] b);
        wr(bscrc_pkg::ADDR_INPUT, b);
        lastIn = b;
        #1 chk8("busy after input", 8'h01, {7'h00, busy});
        chk8("room after input", 8'h01, {7'h00, inputReady});
        @(posedge clk);
        expSum = crc_step(expSum, b, polyNow);
        #1 chk16("checksum", expSum, runningChecksum);
    endtask : feed

    task automatic set_polynomial_select(input logic p);
        wr(bscrc_pkg::ADDR_CTRL, {7'h7F, p});
        polyNow = p;
        rd(bscrc_pkg::ADDR_CTRL, rdVal);
        chk8("control", {7'h00, p}, rdVal);
    endtask : set_polynomial_select

    task automatic load_sum(input logic [15:0] v);
        wr(bscrc_pkg::ADDR_SUM_HIGH, v[15:8]);
        wr(bscrc_pkg::ADDR_SUM_LOW, v[7:0]);
        expSum = v;
        #1 chk16("loaded checksum", v, runningChecksum);
    endtask : load_sum

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        // reset values, status and unmapped places
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0], rdVal);
            chk8("reset read", (a == 4) ? 8'h01 : 8'h00, rdVal);
        end
        wr(3'h5, 8'hA5);
        rd(3'h5, rdVal);
        chk8("unmapped", 8'h00, rdVal);
        $display("test reset done");
        // single bytes from zero and the four-byte stream, both polynomials
        for (int p = 0; p < 2; p++) begin
            set_polynomial_select(p[0]);
            for (int b = 0; b < 8; b++) begin
                load_sum(16'h0000);
                feed(b[7:0]);
                if (b == 7) begin
                    chk16("byte 07", p ? 16'h8011 : 16'h70E7, runningChecksum);
                end
            end
            load_sum(16'h0000);
            for (int k = 0; k < 4; k++) begin
                feed(seqBytes[k]);
            end
            chk16("stream result", p ? 16'h5C43 : 16'hD0FA, runningChecksum);
            rd(bscrc_pkg::ADDR_SUM_HIGH, rdVal);
            chk8("high byte", expSum[15:8], rdVal);
            rd(bscrc_pkg::ADDR_SUM_LOW, rdVal);
            chk8("low byte", expSum[7:0], rdVal);
        end
        $display("test vectors done");
        // random seeds, polynomial changes and bytes
        for (int n = 0; n < 80; n++) begin
            lfsrState = lfsr_next(lfsrState);
            if (lfsrState[3:0] == 4'h0) begin
                set_polynomial_select(lfsrState[4]);
            end else if (lfsrState[3:0] == 4'h1) begin
                load_sum(lfsrState[31:16]);
            end else begin
                feed(lfsrState[15:8]);
                rd(bscrc_pkg::ADDR_INPUT, rdVal);
                chk8("input readback", lfsrState[15:8], rdVal);
                chk16("checksum after read", expSum, runningChecksum);
            end
        end
        $display("test random done");
        // program words, low byte then high, on a cleared pair
        load_sum(16'h0000);
        for (int w = 0; w < 4; w++) begin
            lfsrState = lfsr_next(lfsrState);
            feed(lfsrState[7:0]);
            feed(lfsrState[15:8]);
        end
        $display("test words done");
        // write while the clock enable is low is ignored
        @(posedge clk);
        ce <= 1'h0;
        wr(bscrc_pkg::ADDR_INPUT, 8'h5A);
        @(posedge clk);
        ce <= 1'h1;
        repeat (2) @(posedge clk);
        #1 chk16("frozen checksum", expSum, runningChecksum);
        rd(bscrc_pkg::ADDR_INPUT, rdVal);
        chk8("frozen input", lastIn, rdVal);
        $display("test enable done");
        complete_run;
    end

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        complete_run;
    end
endmodule : bscrc_top_bench
